/* rtl/hisi_top.sv */
// Module: host link selection, status port and interrupt signalling
module hisi_top
   import hisi_pkg::*;
(
   ref_clk,
   nrst,
   external_reset_in,
   tx_strap_in,
   baud_strap_hi,
   baud_strap_mid,
   baud_strap_lo,
   port_select_n,
   par_rd_n,
   par_wr_n,
   par_a0,
   par_d_in,
   par_d_out,
   par_d_oe,
   spi_select,
   spi_shift_bit,
   spi_data_out,
   spi_data_oe,
   irq_raise,
   irq_code,
   cmd_get_status,
   cmd_dataout_as_irq,
   baud_set_stb,
   baud_set_code,
   data_rd_byte,
   if_status,
   link_mode,
   link_ready,
   baud_code,
   host_wr_stb,
   host_wr_cmd,
   host_wr_data,
   host_rd_stb,
   irq_n,
   ser_tx_valid,
   ser_tx_ready,
   ser_tx_byte
);
   input wire logic ref_clk;
   input wire logic nrst;
   input wire logic external_reset_in;
   input wire logic tx_strap_in;
   input wire logic baud_strap_hi;
   input wire logic baud_strap_mid;
   input wire logic baud_strap_lo;
   input wire logic port_select_n;
   input wire logic par_rd_n;
   input wire logic par_wr_n;
   input wire logic par_a0;
   input wire logic [7:0] par_d_in;
   output logic [7:0] par_d_out;
   output logic par_d_oe;
   input wire logic spi_select;
   input wire logic spi_shift_bit;
   output logic spi_data_out;
   output logic spi_data_oe;
   input wire logic irq_raise;
   input wire logic [7:0] irq_code;
   input wire logic cmd_get_status;
   input wire logic cmd_dataout_as_irq;
   input wire logic baud_set_stb;
   input wire logic [2:0] baud_set_code;
   input wire logic [7:0] data_rd_byte;
   input wire logic [6:0] if_status;
   output hisi_link_t link_mode;
   output logic link_ready;
   output logic [2:0] baud_code;
   output logic host_wr_stb;
   output logic host_wr_cmd;
   output logic [7:0] host_wr_data;
   output logic host_rd_stb;
   output logic irq_n;
   output logic ser_tx_valid;
   input wire logic ser_tx_ready;
   output logic [7:0] ser_tx_byte;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   hisi_strap_t strap_raw;
   hisi_strap_t strap_s;
   hisi_par_t par_raw;
   hisi_par_t par_s;
   logic ext_rst_s;
   logic spi_sel_s;

   assign strap_raw = '{tx_strap: tx_strap_in, rd_n: par_rd_n, wr_n: par_wr_n,
                        baud: {baud_strap_hi, baud_strap_mid, baud_strap_lo}};
   assign par_raw = '{cs_n: port_select_n, rd_n: par_rd_n, wr_n: par_wr_n, a0: par_a0, data: par_d_in};

   hisi_sync3 #(.W($bits(hisi_strap_t))) u_sync_strap (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .d_in(strap_raw),
      .q_out(strap_s)
   );

   hisi_sync3 #(.W($bits(hisi_par_t))) u_sync_par (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .d_in(par_raw),
      .q_out(par_s)
   );

   hisi_sync3 #(.W(2)) u_sync_misc (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .d_in({external_reset_in, spi_select}),
      .q_out({ext_rst_s, spi_sel_s})
   );

   // ****************************************
   // External reset filter
   // ****************************************
   logic [2:0] ext_cnt_r;
   logic [2:0] ext_cnt_nxt;
   wire soft_rst = ext_rst_s && (ext_cnt_r == 3'(EXT_RST_CYC));

   assign ext_cnt_nxt = !ext_rst_s ? 3'h0 : (soft_rst ? ext_cnt_r : ext_cnt_r + 3'h1);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ext_cnt_r <= 3'h0;
      end else begin
         ext_cnt_r <= ext_cnt_nxt;
      end
   end

   // ****************************************
   // Strap capture sequence
   // ****************************************
   hisi_state_t state_r;
   hisi_state_t state_nxt;
   logic [2:0] settle_r;
   hisi_link_t mode_r;
   logic [2:0] strap_baud_r;
   wire settle_done = (settle_r == 3'(SETTLE_CYC));

   wire hisi_link_t strap_mode = !strap_s.tx_strap ? HISI_LINK_PAR :
                                 (!strap_s.rd_n && !strap_s.wr_n) ? HISI_LINK_SPI :
                                 HISI_LINK_ASYNC;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         HISI_ST_RESET: state_nxt = HISI_ST_SETTLE;
         HISI_ST_SETTLE: state_nxt = settle_done ? HISI_ST_RUN : HISI_ST_SETTLE;
         HISI_ST_RUN: state_nxt = HISI_ST_RUN;
         default: state_nxt = HISI_ST_RESET;
      endcase
      if (soft_rst) begin
         state_nxt = HISI_ST_RESET;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= HISI_ST_RESET;
         settle_r <= 3'h0;
      end else begin
         state_r <= state_nxt;
         settle_r <= (state_r == HISI_ST_SETTLE) ? settle_r + 3'h1 : 3'h0;
      end
   end

   wire take_strap = (state_r == HISI_ST_SETTLE) && settle_done;
   wire run = (state_r == HISI_ST_RUN);

   // Straps sampled once at the end of reset only
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mode_r <= HISI_LINK_ASYNC;
         strap_baud_r <= BAUD_RST;
      end else if (take_strap) begin
         mode_r <= strap_mode;
         strap_baud_r <= strap_s.baud;
      end
   end

   assign link_mode = mode_r;
   assign link_ready = run;

   // ****************************************
   // Baud rate
   // ****************************************
   logic [2:0] baud_r;

   // Host-driven reset pin returns the default rate
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         baud_r <= BAUD_RST;
      end else if (take_strap) begin
         baud_r <= strap_s.baud;
      end else if (run && baud_set_stb) begin
         baud_r <= baud_set_code;
      end
   end

   assign baud_code = baud_r;

   // ****************************************
   // Interrupt pending
   // ****************************************
   logic pend_r;
   logic pend_nxt;
   wire raise = run && irq_raise;

   // Set wins over the acknowledge; release in one cycle
   assign pend_nxt = raise ? 1'b1 : ((cmd_get_status || !run) ? 1'b0 : pend_r);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pend_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   assign irq_n = !pend_r;

   // ****************************************
   // Parallel port
   // ****************************************
   wire par_on = run && (mode_r == HISI_LINK_PAR);
   wire par_rd = par_on && !par_s.cs_n && !par_s.rd_n;
   wire par_wr = par_on && !par_s.cs_n && !par_s.wr_n;
   wire [7:0] stat_byte = {!pend_r, if_status};
   wire [7:0] rd_byte = par_s.a0 ? stat_byte : data_rd_byte;
   logic par_rd_d_r;
   logic par_wr_d_r;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         par_rd_d_r <= 1'b0;
         par_wr_d_r <= 1'b0;
         par_d_out <= BYTE_RST;
         host_wr_data <= BYTE_RST;
         host_wr_cmd <= 1'b0;
      end else begin
         par_rd_d_r <= par_rd;
         par_wr_d_r <= par_wr;
         if (par_rd) begin
            par_d_out <= rd_byte;
         end
         if (par_wr) begin
            host_wr_data <= par_s.data;
            host_wr_cmd <= par_s.a0;
         end
      end
   end

   // Bus driven only inside a read cycle
   assign par_d_oe = par_rd && par_rd_d_r;
   assign host_rd_stb = par_rd_d_r && !par_rd && !par_s.a0;
   assign host_wr_stb = par_wr_d_r && !par_wr;

   // ****************************************
   // SPI data-out as interrupt
   // ****************************************
   logic sdo_irq_r;
   wire spi_on = run && (mode_r == HISI_LINK_SPI);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sdo_irq_r <= 1'b0;
      end else if (!run) begin
         sdo_irq_r <= 1'b0;
      end else if (spi_on && cmd_dataout_as_irq) begin
         sdo_irq_r <= 1'b1;
      end
   end

   // Select high means inactive
   assign spi_data_out = spi_sel_s ? !pend_r : spi_shift_bit;
   assign spi_data_oe = spi_on && (!spi_sel_s || sdo_irq_r);

   // ****************************************
   // Async serial status push
   // ****************************************
   logic tx_valid_r;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx_valid_r <= 1'b0;
         ser_tx_byte <= BYTE_RST;
      end else if (raise && (mode_r == HISI_LINK_ASYNC)) begin
         tx_valid_r <= 1'b1;
         ser_tx_byte <= irq_code;
      end else if (ser_tx_ready || !run) begin
         tx_valid_r <= 1'b0;
      end
   end

   assign ser_tx_valid = tx_valid_r;

endmodule : hisi_top

/* rtl/hisi_pkg.sv */
// Package: constants and types for the host interface select and interrupt block
package hisi_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int EXT_RST_MIN_NS = 100;
   localparam int EXT_RST_CYC = (EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IRQ_REL_MAX_NS = 2000;
   localparam int IRQ_REL_CYC = IRQ_REL_MAX_NS / CLK_PERIOD_NS;
   localparam int SETTLE_CYC = 4;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int STAT_IRQ_BIT = 7;
   localparam logic [2:0] BAUD_RST = 3'h7;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      HISI_LINK_PAR = 2'b00,
      HISI_LINK_SPI = 2'b01,
      HISI_LINK_ASYNC = 2'b11
   } hisi_link_t;

   typedef enum logic [1:0] {
      HISI_ST_RESET = 2'b00,
      HISI_ST_SETTLE = 2'b01,
      HISI_ST_RUN = 2'b11
   } hisi_state_t;

   typedef struct packed {
      logic tx_strap;
      logic rd_n;
      logic wr_n;
      logic [2:0] baud;
   } hisi_strap_t;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic a0;
      logic [7:0] data;
   } hisi_par_t;

endpackage : hisi_pkg

/* rtl/hisi_sync3.sv */
// Module: three-stage input synchroniser with agreement filter
module hisi_sync3 #(
   parameter int W = 1
) (
   ref_clk,
   nrst,
   d_in,
   q_out
);
   input wire logic ref_clk;
   input wire logic nrst;
   input wire logic [W-1:0] d_in;
   output logic [W-1:0] q_out;

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // Only the second and third stages are compared
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_out <= '0;
      end else begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            q_out <= s3_r;
         end
      end
   end

endmodule : hisi_sync3

/* tb/hisi_host_rx.sv */
// Host-side serial receiver model with a settable stall
module hisi_host_rx (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [2:0] wait_cyc,
   input wire logic ser_tx_valid,
   input wire logic [7:0] ser_tx_byte,
   output logic ser_tx_ready,
   output logic [7:0] rx_byte,
   output logic [7:0] rx_count
);
   logic [2:0] stall_r;
   // ********
   // Receiver
   // ********
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         {stall_r, ser_tx_ready, rx_byte, rx_count} <= '0;
      end else begin
         ser_tx_ready <= 1'b0;
         if (ser_tx_valid && !ser_tx_ready) begin
            stall_r <= (stall_r == wait_cyc) ? 3'h0 : stall_r + 3'h1;
            ser_tx_ready <= (stall_r == wait_cyc);
         end
         if (ser_tx_valid && ser_tx_ready) begin
            rx_byte <= ser_tx_byte;
            rx_count <= rx_count + 8'h01;
         end
      end
   end
endmodule : hisi_host_rx

/* tb/hisi_top_properties.sv */
// Checker: port properties of the host link select and interrupt block
module hisi_top_properties
   import hisi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic irq_raise,
   input wire logic [7:0] irq_code,
   input wire logic cmd_get_status,
   input wire logic link_ready,
   input wire hisi_link_t link_mode,
   input wire logic irq_n,
   input wire logic par_d_oe,
   input wire logic spi_data_oe,
   input wire logic spi_select,
   input wire logic spi_data_out,
   input wire logic ser_tx_valid,
   input wire logic ser_tx_ready,
   input wire logic [7:0] ser_tx_byte,
   input wire logic [2:0] baud_code,
   input wire logic baud_strap_hi,
   input wire logic baud_strap_mid,
   input wire logic baud_strap_lo
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   AST_IRQ_SET: assert property (irq_raise && link_ready |=> !irq_n)
      else $error("irq_n not low after raise");
   AST_IRQ_HOLD: assert property (!irq_n && !cmd_get_status |=> !irq_n)
      else $error("irq_n released unasked");
   AST_IRQ_ACK: assert property (cmd_get_status && !irq_raise && link_ready |=> irq_n)
      else $error("irq_n kept after status");
   AST_PAR_OE: assert property (par_d_oe |-> link_ready && link_mode == HISI_LINK_PAR)
      else $error("parallel drive off mode");
   AST_SDO_MODE: assert property (spi_data_oe |-> link_ready && link_mode == HISI_LINK_SPI)
      else $error("data out drive off mode");
   AST_SDO_IRQ: assert property (spi_select [*5] ##0 spi_data_oe |-> spi_data_out == irq_n)
      else $error("data out not irq level");
   AST_SER_TX: assert property (irq_raise && link_ready && link_mode == HISI_LINK_ASYNC |=>
      ser_tx_valid && ser_tx_byte == $past(irq_code)) else $error("status byte not sent");
   AST_SER_HOLD: assert property (ser_tx_valid && !ser_tx_ready && !irq_raise |=>
      ser_tx_valid && $stable(ser_tx_byte)) else $error("byte dropped early");
   AST_MODE_FIXED: assert property (link_ready && $past(link_ready) |-> $stable(link_mode))
      else $error("link changed in run");
   AST_BAUD_DEF: assert property ($rose(link_ready) && link_mode == HISI_LINK_ASYNC |->
      baud_code == {baud_strap_hi, baud_strap_mid, baud_strap_lo}) else $error("baud not default");
   cover property (!irq_n ##1 cmd_get_status ##1 irq_n);
   cover property (ser_tx_valid && ser_tx_ready);
   cover property (spi_data_oe && spi_select && !spi_data_out);
endmodule : hisi_top_properties

bind hisi_top hisi_top_properties i_props (.*);

/* tb/hisi_top_tb.sv */
// Testbench: strap boots, interrupt paths, status port and baud restore
module host_interface_select_irq_tb import hisi_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, nrst, external_reset_in, tx_strap_in, baud_strap_hi, baud_strap_mid, baud_strap_lo;
   logic port_select_n, par_rd_n, par_wr_n, par_a0, par_d_oe, spi_select, spi_shift_bit, spi_data_out;
   logic spi_data_oe, irq_raise, cmd_get_status, cmd_dataout_as_irq, baud_set_stb, link_ready, host_wr_stb;
   logic host_wr_cmd, host_rd_stb, irq_n, ser_tx_valid, ser_tx_ready;
   logic [7:0] par_d_in, par_d_out, irq_code, data_rd_byte, host_wr_data, ser_tx_byte, rx_byte, rx_count, s;
   logic [6:0] if_status;
   logic [2:0] baud_set_code, baud_code, wait_cyc;
   hisi_link_t link_mode;
   int seed = 610, bad_count = 0, n_checks = 0, cyc = 0, k, n_rd_stb = 0, rd0;
   hisi_top i_dut (.*);
   hisi_host_rx i_host (.*);
   initial ref_clk = 1'b0;
   always #10 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      if (host_rd_stb === 1'b1) begin
         n_rd_stb++;
      end
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   task chk(input logic [7:0] g, e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   function hisi_link_t exp_mode(input logic tx, rw);
      return !tx ? HISI_LINK_PAR : (!rw ? HISI_LINK_SPI : HISI_LINK_ASYNC);
   endfunction : exp_mode
   task pulse(input logic r, a, d);
      @(posedge ref_clk);
      {irq_raise, cmd_get_status, cmd_dataout_as_irq, irq_code} <= {r, a, d, 8'($random(seed))};
      @(posedge ref_clk);
      {irq_raise, cmd_get_status, cmd_dataout_as_irq} <= 3'h0;
      @(negedge ref_clk);
   endtask : pulse
   task ready_wait();
      k = 0;
      while (link_ready !== 1'b1 && k < 60) begin
         @(negedge ref_clk);
         k++;
      end
      chk(8'(link_ready), 8'h01);
      @(posedge ref_clk);
   endtask : ready_wait
   task boot(input logic tx, rw);
      @(posedge ref_clk);
      {nrst, tx_strap_in, par_rd_n, par_wr_n} <= {1'b0, tx, rw, rw};
      {baud_strap_hi, baud_strap_mid, baud_strap_lo, wait_cyc} <= 6'($random(seed));
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      ready_wait();
      {par_rd_n, par_wr_n} <= 2'h3;
      chk(8'(link_mode), 8'(exp_mode(tx, rw)));
      if (tx && rw) begin
         chk(8'(baud_code), 8'({baud_strap_hi, baud_strap_mid, baud_strap_lo}));
      end
   endtask : boot
   task par_rd(input logic a);
      @(posedge ref_clk);
      {port_select_n, par_rd_n, par_a0} <= {2'h0, a};
      k = 0;
      while (par_d_oe !== 1'b1 && k < 20) begin
         @(negedge ref_clk);
         k++;
      end
      chk(8'(par_d_oe), 8'h01);
      s = par_d_out;
      @(posedge ref_clk);
      {port_select_n, par_rd_n} <= 2'h3;
      repeat (5) @(posedge ref_clk);
   endtask : par_rd
   task irq_t();
      if (link_mode === HISI_LINK_SPI) begin
         pulse(1'b0, 1'b0, 1'b1);
      end
      s = rx_count;
      pulse(1'b1, 1'b0, 1'b0);
      chk(8'(irq_n), 8'h00);
      if (link_mode === HISI_LINK_PAR) begin
         rd0 = n_rd_stb;
         par_rd(1'b1);
         chk(s, {1'b0, if_status});
         par_rd(1'b0);
         chk(s, data_rd_byte);
         chk(8'(n_rd_stb - rd0), 8'h01);
         @(posedge ref_clk);
         par_rd_n <= 1'b0;
         repeat (8) @(negedge ref_clk) chk(8'(par_d_oe), 8'h00);
         @(posedge ref_clk);
         {port_select_n, par_rd_n, par_wr_n, par_d_in} <= {3'h2, irq_code};
         repeat (6) @(posedge ref_clk);
         {port_select_n, par_wr_n} <= 2'h3;
         k = 0;
         while (host_wr_stb !== 1'b1 && k < 20) begin
            @(negedge ref_clk);
            k++;
         end
         chk(8'(host_wr_stb), 8'h01);
         chk(8'(host_wr_cmd), 8'(par_a0));
         chk(host_wr_data, irq_code);
      end else if (link_mode === HISI_LINK_SPI) begin
         repeat (6) @(negedge ref_clk);
         chk(8'(spi_data_oe), 8'h01);
         chk(8'(spi_data_out), 8'h00);
         @(posedge ref_clk);
         spi_select <= 1'b0;
         repeat (6) @(negedge ref_clk);
         chk(8'(spi_data_out), 8'(spi_shift_bit));
         @(posedge ref_clk);
         spi_select <= 1'b1;
      end else begin
         k = 0;
         while (rx_count === s && k < 40) begin
            @(negedge ref_clk);
            k++;
         end
         chk(rx_count, s + 8'h01);
         chk(rx_byte, irq_code);
      end
      pulse(1'b1, 1'b1, 1'b0);
      chk(8'(irq_n), 8'h00);
      pulse(1'b0, 1'b1, 1'b0);
      chk(8'(irq_n), 8'h01);
      if (link_mode === HISI_LINK_PAR) begin
         par_rd(1'b1);
         chk(s, {1'b1, if_status});
      end
   endtask : irq_t
   initial begin
      {nrst, external_reset_in, irq_raise, cmd_get_status, cmd_dataout_as_irq, baud_set_stb, par_a0} = '0;
      {tx_strap_in, baud_strap_hi, baud_strap_mid, baud_strap_lo, port_select_n, par_rd_n, par_wr_n} = '1;
      {spi_select, par_d_in, irq_code, baud_set_code, wait_cyc} = {1'b1, 22'h0};
      {if_status, data_rd_byte, spi_shift_bit} = 16'($random(seed));
      for (int m = 0; m < 4; m++) begin
         boot(m[1], m[0]);
         irq_t();
      end
      @(posedge ref_clk);
      {baud_set_stb, baud_set_code} <= {1'b1, ~baud_strap_hi, baud_strap_mid, baud_strap_lo};
      @(posedge ref_clk);
      baud_set_stb <= 1'b0;
      @(negedge ref_clk);
      chk(8'(baud_code), 8'(baud_set_code));
      @(posedge ref_clk);
      external_reset_in <= 1'b1;
      k = 0;
      while (link_ready === 1'b1 && k < 30) begin
         @(negedge ref_clk);
         k++;
      end
      @(posedge ref_clk);
      external_reset_in <= 1'b0;
      ready_wait();
      chk(8'(baud_code), 8'({baud_strap_hi, baud_strap_mid, baud_strap_lo}));
      irq_t();
      wrap_up();
   end
endmodule : host_interface_select_irq_tb
